/* File: pkg/shp_pkg.sv */
/*
  shp_pkg: constants, states and helpers for the stepper homing and
  positioning controller.
  assumes a 25 MHz system clock; no bus, all settings are plain ports.
*/
`default_nettype none
package shp_pkg;
  // position and step widths
  localparam int POS_W = 16;
  // bus address limits and default
  localparam logic [4:0] ADDR_DEFAULT = 5'h04;
  localparam logic [4:0] ADDR_MAX = 5'h1e;
  // step rate periods in ns
  localparam int STEP_NORMAL_NS = 2000000;
  localparam int STEP_SLOW_NS = 4000000;
  localparam int STEP_LONGCBL_NS = 6000000;
  localparam int CLK_NS = 40;
  // step periods in clock cycles, rounded down, at least one
  localparam int STEP_NORMAL_CYC = STEP_NORMAL_NS / CLK_NS;
  localparam int STEP_SLOW_CYC = STEP_SLOW_NS / CLK_NS;
  localparam int STEP_LONGCBL_CYC = STEP_LONGCBL_NS / CLK_NS;
  // travel and reference search limits
  localparam logic [POS_W-1:0] TRAVEL_LIMIT = 16'h2000;
  localparam logic [POS_W-1:0] REF_SEARCH_LIMIT = 16'h1000;
  localparam logic [3:0] REF_OVERSHOOT = 4'h4;
  localparam logic [POS_W-1:0] STEPS_PER_REV = 16'h00c8;
  // failing phase codes
  localparam logic [1:0] PH_NONE = 2'h0;
  localparam logic [1:0] PH_MAX = 2'h1;
  localparam logic [1:0] PH_CHECK = 2'h2;
  localparam logic [1:0] PH_REF = 2'h3;
  // controller states
  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT_ACK, ST_SEEK_MAX, ST_CHECK, ST_SEEK_REF,
    ST_PAST_REF, ST_BACK_REF, ST_READY, ST_MOVE, ST_ERROR
  } shp_state_type;
  // address range check used on every address write
  function automatic logic shp_addr_ok(input logic [7:0] a);
    return a <= {3'h0, ADDR_MAX};
  endfunction
endpackage
`default_nettype wire

/* File: logic/shp_step_timer.sv */
/*
  shp_step_timer: one-cycle step enable at a selectable period.
  assumes the caller picks the period each cycle; run low restarts it.
*/
`timescale 1ns/1ps
`default_nettype none
module shp_step_timer
  import shp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // control
  input  wire logic        run_i,
  input  wire logic [18:0] period_i,
  // step pulse
  output logic             tick_o
);
  // counter state
  typedef struct packed {
    logic [18:0] cnt;
    logic        tick;
  } shp_tmr_type;
  shp_tmr_type st_q, st_d;
  // next count
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!run_i) begin
      st_d.cnt = '0;
    end else if (st_q.cnt + 19'h1 >= period_i) begin
      st_d.cnt = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 19'h1;
    end
  end
  // register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign tick_o = st_q.tick;
endmodule
`default_nettype wire

/* File: logic/shp_settings.sv */
/*
  shp_settings: system-wide settings, bus address with range check.
  assumes values load from non-volatile storage by a load pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module shp_settings
  import shp_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // address write and restore
  input  wire logic       addr_wr_i,
  input  wire logic [7:0] addr_val_i,
  input  wire logic       nv_load_i,
  input  wire logic [4:0] nv_addr_i,
  // outputs
  output logic [4:0]      addr_o,
  output logic            addr_rej_o
);
  // settings state
  typedef struct packed {
    logic [4:0] addr;
    logic       rej;
  } shp_set_type;
  shp_set_type st_q, st_d;
  // accept only 0..30, else keep old value
  always_comb begin
    st_d = st_q;
    st_d.rej = 1'b0;
    if (nv_load_i && shp_addr_ok({3'h0, nv_addr_i})) begin
      st_d.addr = nv_addr_i;
    end else if (addr_wr_i) begin
      if (shp_addr_ok(addr_val_i)) begin
        st_d.addr = addr_val_i[4:0];
      end else begin
        st_d.rej = 1'b1;
      end
    end
  end
  // register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '{addr: ADDR_DEFAULT, rej: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end
  assign addr_o = st_q.addr;
  assign addr_rej_o = st_q.rej;
  a_addr_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    addr_o <= ADDR_MAX) else $error("address out of range");
  a_addr_reject: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (addr_wr_i && !nv_load_i && addr_val_i > 8'h1e) |=> (addr_o == $past(addr_o) && addr_rej_o))
    else $error("bad address not rejected");
endmodule
`default_nettype wire

/* File: logic/shp_channel_ctrl.sv */
/*
  shp_channel_ctrl: homing and positioning for one stepper channel with
  max, min and reference sensors; top instance of this block.
  assumes sensor inputs synchronous to SYS_CLK_I; power-up homing order
  between channels is sequenced by the start/done ports of each channel.
*/
// Overview of operation
// - home on power-up, reset, connect, mode, overrange
// - phase one steps toward max until sensor
// - phase two: min, ref clear with max
// - phase three seeks reference at slow rate
// - overshoot and return; reference one step only
// - unexpected sensor behaviour raises error flag
// - clean homing marks channel initialised, ready
// - channel settings only affect active channel
// - enables restored from storage at power-up
// - steps mode uses raw step counts
// - steps mode reports steps from reference
// - value mode uses dB or degree units
// - high attenuation overrange goes to max
// - at max position report max indication
// - no increments at max; in-range setting leaves
// - high attenuation ignored in steps mode
// - reference checked when a move ends at zero
// - checking off skips reference verification
// - long cable slows and alters drive
// - restore only with same instrument type
// - bus address default 4, range 0..30
// - first channel homes before second channel
// - homing disabled waits for operator acknowledge
`timescale 1ns/1ps
`default_nettype none
module shp_channel_ctrl
(
  // clock and reset
  input  wire logic                     SYS_CLK_I,
  input  wire logic                     RESET_N_I,
  // homing triggers
  input  wire logic                     POWERUP_START_I,
  input  wire logic                     BUS_RESET_CMD_I,
  input  wire logic                     INST_CONNECT_I,
  input  wire logic                     OPERATOR_ACKNOWLEDGE_CMD_I,
  // settings source
  input  wire logic                     CHAN_ACTIVE_I,
  input  wire logic                     RAW_STEP_MODE_CMD_I,
  input  wire logic                     VALUE_MODE_CMD_I,
  input  wire logic                     HIGH_ATTEN_CMD_I,
  input  wire logic                     HIGH_ATTEN_VAL_I,
  input  wire logic                     REF_CHECK_CMD_I,
  input  wire logic                     REF_CHECK_VAL_I,
  input  wire logic                     EXTENDED_CABLE_DRIVE_CMD_I,
  input  wire logic                     EXTENDED_CABLE_DRIVE_VAL_I,
  input  wire logic                     POWERUP_HOMING_ENABLE_I,
  input  wire logic                     RESTORE_ON_POWERUP_I,
  // non-volatile reload
  input  wire logic                     NV_LOAD_I,
  input  wire logic [3:0]               NV_FLAGS_I,
  input  wire logic [shp_pkg::POS_W-1:0] NV_POS_I,
  input  wire logic [1:0]               NV_INST_TYPE_I,
  // bus address setting
  input  wire logic                     BUS_ADDRESS_SET_I,
  input  wire logic [7:0]               BUS_ADDRESS_VAL_I,
  // positioning commands, target in steps already scaled by unit
  input  wire logic                     SET_CMD_I,
  input  wire logic                     INC_CMD_I,
  input  wire logic                     DEC_CMD_I,
  input  wire logic [shp_pkg::POS_W-1:0] SET_STEPS_I,
  input  wire logic [shp_pkg::POS_W-1:0] INC_STEPS_I,
  input  wire logic [shp_pkg::POS_W-1:0] MAX_STEPS_I,
  input  wire logic [shp_pkg::POS_W-1:0] HIGH_ATTEN_STEPS_I,
  // instrument
  input  wire logic [1:0]               INST_TYPE_I,
  input  wire logic                     INST_IS_ATTEN_I,
  input  wire logic                     SENSE_MAX_I,
  input  wire logic                     SENSE_MIN_I,
  input  wire logic                     SENSE_REF_I,
  output logic                          STEP_O,
  output logic                          DIR_UP_O,
  output logic                          LONG_DRIVE_O,
  // status
  output logic                          HOMING_DONE_O,
  output logic                          INITIALISED_O,
  output logic                          ERROR_O,
  output logic [1:0]                    ERROR_PHASE_O,
  output logic                          STEPS_MODE_O,
  output logic                          AT_MAX_O,
  output logic [shp_pkg::POS_W-1:0]      POSITION_O,
  output logic                          REF_CHECK_O,
  output logic [4:0]                    BUS_ADDRESS_O,
  output logic                          BUS_ADDRESS_REJECT_O
);
  import shp_pkg::*;
  // whole channel state
  typedef struct packed {
    shp_state_type st;
    logic [POS_W-1:0] pos;      // steps from reference
    logic [POS_W-1:0] tgt;      // move target
    logic [POS_W-1:0] cnt;      // phase step counter
    logic [3:0] ovs;            // overshoot count
    logic [3:0] refhits;        // ref sightings during overshoot
    logic steps_mode;
    logic high_en;
    logic ref_chk;
    logic long_cbl;
    logic at_max;
    logic restore_pend;
    logic err;
    logic [1:0] err_ph;
    logic step;
    logic dir_up;
    logic done;
    logic init;                 // channel initialised
  } shp_chan_type;
  shp_chan_type s_q, s_d;
  logic        tick, moving, overrange, ref_seen; // step tick, motion, range, ref at zero
  logic [18:0] period;                            // step period in cycles
  // step rate: slow in reference seek and overshoot, slower still with long cable
  always_comb begin
    if (s_q.long_cbl) begin
      period = 19'(STEP_LONGCBL_CYC);
    end else if (s_q.st == ST_SEEK_REF || s_q.st == ST_PAST_REF || s_q.st == ST_BACK_REF) begin
      period = 19'(STEP_SLOW_CYC);
    end else begin
      period = 19'(STEP_NORMAL_CYC);
    end
  end
  assign moving = s_q.st inside {ST_SEEK_MAX, ST_SEEK_REF, ST_PAST_REF, ST_BACK_REF, ST_MOVE};
  shp_step_timer u_tmr (
    .clk_i    (SYS_CLK_I),
    .rst_n_i  (RESET_N_I),
    .run_i    (moving),
    .period_i (period),
    .tick_o   (tick)
  );
  shp_settings u_set (
    .clk_i      (SYS_CLK_I),
    .rst_n_i    (RESET_N_I),
    .addr_wr_i  (BUS_ADDRESS_SET_I),
    .addr_val_i (BUS_ADDRESS_VAL_I),
    .nv_load_i  (1'b0),
    .nv_addr_i  (ADDR_DEFAULT),
    .addr_o     (BUS_ADDRESS_O),
    .addr_rej_o (BUS_ADDRESS_REJECT_O)
  );
  assign overrange = SET_STEPS_I > MAX_STEPS_I;
  // reference sensor seen with the step count at zero
  assign ref_seen = SENSE_REF_I && s_q.pos == '0;
  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.step = 1'b0;
    s_d.done = 1'b0;
    // channel-scoped settings only for the active channel
    if (CHAN_ACTIVE_I) begin
      if (HIGH_ATTEN_CMD_I) s_d.high_en = HIGH_ATTEN_VAL_I;
      if (REF_CHECK_CMD_I) s_d.ref_chk = REF_CHECK_VAL_I;
      if (EXTENDED_CABLE_DRIVE_CMD_I) s_d.long_cbl = EXTENDED_CABLE_DRIVE_VAL_I;
      if (RAW_STEP_MODE_CMD_I) s_d.steps_mode = 1'b1;
    end
    // enable flags reloaded from storage
    if (NV_LOAD_I) begin
      s_d.high_en = NV_FLAGS_I[0];
      s_d.ref_chk = NV_FLAGS_I[1];
      s_d.long_cbl = NV_FLAGS_I[2];
      s_d.steps_mode = NV_FLAGS_I[3];
      s_d.restore_pend = RESTORE_ON_POWERUP_I && NV_INST_TYPE_I == INST_TYPE_I;
      s_d.tgt = NV_POS_I;
    end
    case (s_q.st)
      ST_IDLE, ST_READY, ST_ERROR: begin
        // homing triggers
        if (POWERUP_START_I) begin
          s_d.st = POWERUP_HOMING_ENABLE_I ? ST_SEEK_MAX : ST_WAIT_ACK;
          s_d.restore_pend = s_d.restore_pend && POWERUP_HOMING_ENABLE_I;
        end else if (BUS_RESET_CMD_I || INST_CONNECT_I ||
                     (CHAN_ACTIVE_I && VALUE_MODE_CMD_I && s_q.steps_mode)) begin
          s_d.st = ST_SEEK_MAX;
          s_d.steps_mode = 1'b0;
        end else if (s_q.st == ST_READY && CHAN_ACTIVE_I && SET_CMD_I) begin
          if (!overrange) begin
            s_d.at_max = 1'b0;
            s_d.tgt = SET_STEPS_I;
            s_d.st = ST_MOVE;
          end else if (s_q.high_en && INST_IS_ATTEN_I && !s_q.steps_mode) begin
            s_d.at_max = 1'b1;
            s_d.tgt = HIGH_ATTEN_STEPS_I;
            s_d.st = ST_MOVE;
          end else begin
            s_d.st = ST_SEEK_MAX;
          end
        end else if (s_q.st == ST_READY && CHAN_ACTIVE_I && !s_q.at_max &&
                     (INC_CMD_I || DEC_CMD_I)) begin
          if (INC_CMD_I && {1'b0, s_q.pos} + {1'b0, INC_STEPS_I} <= {1'b0, MAX_STEPS_I}) begin
            s_d.tgt = s_q.pos + INC_STEPS_I;
            s_d.st = ST_MOVE;
          end else if (DEC_CMD_I && s_q.pos >= INC_STEPS_I) begin
            s_d.tgt = s_q.pos - INC_STEPS_I;
            s_d.st = ST_MOVE;
          end
        end
      end
      ST_WAIT_ACK: begin
        // paused until operator says go
        if (OPERATOR_ACKNOWLEDGE_CMD_I) s_d.st = ST_SEEK_MAX;
      end
      ST_SEEK_MAX: begin
        s_d.dir_up = 1'b1;
        if (SENSE_MAX_I) begin
          s_d.st = ST_CHECK;
        end else if (tick) begin
          s_d.step = 1'b1;
          s_d.cnt = s_q.cnt + 16'h1;
          if (s_q.cnt == TRAVEL_LIMIT) begin
            s_d.st = ST_ERROR;
            s_d.err = 1'b1;
            s_d.err_ph = PH_MAX;
          end
        end
      end
      ST_CHECK: begin
        if (SENSE_MIN_I || SENSE_REF_I) begin
          s_d.st = ST_ERROR;
          s_d.err = 1'b1;
          s_d.err_ph = PH_CHECK;
        end else begin
          s_d.st = ST_SEEK_REF;
          s_d.cnt = '0;
        end
      end
      ST_SEEK_REF: begin
        s_d.dir_up = 1'b0;
        if (SENSE_REF_I) begin
          s_d.st = ST_PAST_REF;
          s_d.ovs = '0;
          s_d.refhits = '0;
        end else if (tick) begin
          s_d.step = 1'b1;
          s_d.cnt = s_q.cnt + 16'h1;
          if (s_q.cnt == REF_SEARCH_LIMIT || SENSE_MIN_I) begin
            s_d.st = ST_ERROR;
            s_d.err = 1'b1;
            s_d.err_ph = PH_REF;
          end
        end
      end
      ST_PAST_REF, ST_BACK_REF: begin
        // step past and back, ref must show at one position only
        s_d.dir_up = (s_q.st == ST_BACK_REF);
        if (tick) begin
          s_d.step = 1'b1;
          s_d.ovs = s_q.ovs + 4'h1;
          if (SENSE_REF_I) s_d.refhits = s_q.refhits + 4'h1;
          if (s_q.ovs == REF_OVERSHOOT) begin
            s_d.ovs = '0;
            if (s_q.st == ST_PAST_REF) begin
              s_d.st = ST_BACK_REF;
            end else if (s_d.refhits != 4'h1) begin
              s_d.st = ST_ERROR;
              s_d.err = 1'b1;
              s_d.err_ph = PH_REF;
            end else begin
              s_d.st = ST_READY;
              s_d.pos = '0;
              s_d.done = 1'b1;
              if (s_q.restore_pend) begin
                s_d.st = ST_MOVE;
                s_d.restore_pend = 1'b0;
              end
            end
          end
        end
      end
      ST_MOVE: begin
        if (s_q.pos == s_q.tgt && !s_q.step) begin
          // arrival at zero checks the sensor once the last step has landed
          s_d.st = ST_READY;
          if (s_q.ref_chk && s_q.tgt == '0 && !ref_seen) begin
            s_d.st = ST_ERROR;
            s_d.err = 1'b1;
            s_d.err_ph = PH_REF;
          end
        end else if (tick && s_q.pos != s_q.tgt) begin
          s_d.step = 1'b1;
          s_d.dir_up = s_q.tgt > s_q.pos;
          s_d.pos = s_d.dir_up ? s_q.pos + 16'h1 : s_q.pos - 16'h1;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    if (s_d.st == ST_SEEK_MAX && s_q.st != ST_SEEK_MAX) begin // new homing run starts clean
      s_d.err = 1'b0;
      s_d.err_ph = PH_NONE;
      s_d.at_max = 1'b0;
      s_d.cnt = '0;
    end
    s_d.init = s_d.st inside {ST_READY, ST_MOVE};
  end
  // register
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s_q <= '0;                // idle is the first, all-zero state
      s_q.ref_chk <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
  assign STEP_O = s_q.step;
  assign DIR_UP_O = s_q.dir_up;
  assign LONG_DRIVE_O = s_q.long_cbl;
  assign HOMING_DONE_O = s_q.done;
  assign INITIALISED_O = s_q.init;
  assign ERROR_O = s_q.err;
  assign ERROR_PHASE_O = s_q.err_ph;
  assign STEPS_MODE_O = s_q.steps_mode;
  assign AT_MAX_O = s_q.at_max;
  assign POSITION_O = s_q.pos;
  assign REF_CHECK_O = s_q.ref_chk;
  // sequences of the homing walk
  sequence s_max_hit;
    s_q.st == ST_SEEK_MAX && SENSE_MAX_I;
  endsequence
  a_max_to_check: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    s_max_hit |=> s_q.st == ST_CHECK) else $error("max sensor ignored");
  a_check_error: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (s_q.st == ST_CHECK && (SENSE_MIN_I || SENSE_REF_I)) |=>
    (ERROR_O && ERROR_PHASE_O == PH_CHECK)) else $error("sensor clash missed");
  a_ack_wait: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (s_q.st == ST_WAIT_ACK && !OPERATOR_ACKNOWLEDGE_CMD_I) |=> s_q.st == ST_WAIT_ACK)
    else $error("homing left pause unacked");
  a_max_no_inc: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (s_q.st == ST_READY && AT_MAX_O && !SET_CMD_I && !BUS_RESET_CMD_I && !INST_CONNECT_I
     && !POWERUP_START_I && !VALUE_MODE_CMD_I) |=> s_q.st == ST_READY)
    else $error("increment at max");
  a_init_done: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    HOMING_DONE_O |-> (POSITION_O == '0 && !ERROR_O)) else $error("bad done");
  a_err_phase: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    $rose(ERROR_O) |-> ERROR_PHASE_O != PH_NONE) else $error("no phase");
endmodule
`default_nettype wire

/* File: bench/shp_inst_model.sv */
/*
  shp_inst_model: stepper instrument with max, min and reference sensors.
  assumes step pulses and direction come from the controller's outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module shp_inst_model #(
  parameter int TOP_POS   = 300,                  // max sensor position
  parameter int REF_POS   = 100,                  // reference position
  parameter int START_POS = 299                   // shaft position at start
) (
  // clock and drive
  input  wire logic clk_i,
  input  wire logic step_i,
  input  wire logic dir_up_i,
  // fault injection
  input  wire logic fault_min_i,
  // sensors
  output logic      sense_max_o,
  output logic      sense_min_o,
  output logic      sense_ref_o
);
  int pos = START_POS;                            // shaft position in steps
  // one step per pulse, clamped to the travel
  always @(posedge clk_i) begin
    if (step_i && dir_up_i && pos < TOP_POS) begin
      pos <= pos + 1;
    end else if (step_i && !dir_up_i && pos > 0) begin
      pos <= pos - 1;
    end
  end
  // sensors; fault shows min together with max
  assign sense_max_o = (pos >= TOP_POS);
  assign sense_min_o = (pos == 0) || (fault_min_i && sense_max_o);
  assign sense_ref_o = (pos == REF_POS);
endmodule
`default_nettype wire

/* File: bench/tb.sv */
/*
  tb: self-checking bench for the channel controller.
  assumes fixed step periods, so only the first homing step is awaited.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import shp_pkg::*;
  logic clk = 0, rst_n = 0;                       // clock and reset
  logic pu = 0, brst = 0, conn = 0, ack = 0;      // homing triggers
  logic act = 1, stc = 0, vmc = 0, hac = 0, hav = 0;
  logic rcc = 0, rcv = 0, ecc = 0, ecv = 0, phe = 1, rop = 0;
  logic nvl = 0;                                  // storage reload
  logic [3:0] nvf = 4'h0;
  logic [1:0] nvt = 2'h0, ityp = 2'h1;
  logic [POS_W-1:0] nvp = 16'h0000, sst = 16'h0000, ist = 16'h0001;
  logic [POS_W-1:0] mst = 16'h0100, hst = 16'h0120, pos;
  logic bas = 0, setc = 0, incc = 0, decc = 0, isat = 1, fmin = 0;
  logic [7:0] bav = 8'h00;
  logic smax, smin, sref, step, dup, ldr, hd, ini, err, stm, amax, rco;
  logic [1:0] eph;
  logic [4:0] badr;
  logic brej;
  int fail_count = 0, cmp_count = 0;
  // clock, 40 ns period
  initial begin
    forever #20 clk = ~clk;
  end
  shp_inst_model inst_u (.clk_i(clk), .step_i(step), .dir_up_i(dup), .fault_min_i(fmin),
    .sense_max_o(smax), .sense_min_o(smin), .sense_ref_o(sref));
  shp_channel_ctrl dut_u (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .POWERUP_START_I(pu),
    .BUS_RESET_CMD_I(brst), .INST_CONNECT_I(conn), .OPERATOR_ACKNOWLEDGE_CMD_I(ack),
    .CHAN_ACTIVE_I(act), .RAW_STEP_MODE_CMD_I(stc), .VALUE_MODE_CMD_I(vmc),
    .HIGH_ATTEN_CMD_I(hac), .HIGH_ATTEN_VAL_I(hav), .REF_CHECK_CMD_I(rcc),
    .REF_CHECK_VAL_I(rcv), .EXTENDED_CABLE_DRIVE_CMD_I(ecc),
    .EXTENDED_CABLE_DRIVE_VAL_I(ecv), .POWERUP_HOMING_ENABLE_I(phe),
    .RESTORE_ON_POWERUP_I(rop), .NV_LOAD_I(nvl), .NV_FLAGS_I(nvf), .NV_POS_I(nvp),
    .NV_INST_TYPE_I(nvt), .BUS_ADDRESS_SET_I(bas), .BUS_ADDRESS_VAL_I(bav),
    .SET_CMD_I(setc), .INC_CMD_I(incc), .DEC_CMD_I(decc), .SET_STEPS_I(sst),
    .INC_STEPS_I(ist), .MAX_STEPS_I(mst), .HIGH_ATTEN_STEPS_I(hst),
    .INST_TYPE_I(ityp), .INST_IS_ATTEN_I(isat), .SENSE_MAX_I(smax), .SENSE_MIN_I(smin),
    .SENSE_REF_I(sref), .STEP_O(step), .DIR_UP_O(dup), .LONG_DRIVE_O(ldr),
    .HOMING_DONE_O(hd), .INITIALISED_O(ini), .ERROR_O(err), .ERROR_PHASE_O(eph),
    .STEPS_MODE_O(stm), .AT_MAX_O(amax), .POSITION_O(pos), .REF_CHECK_O(rco),
    .BUS_ADDRESS_O(badr), .BUS_ADDRESS_REJECT_O(brej));
  // compare one value, counting mismatches
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // let the command edge and the state change land
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask
  // reset values of the status outputs
  task automatic t_reset();
    chk("ref_check", 16'h1, {15'h0, rco});
    chk("bus_addr", {11'h0, ADDR_DEFAULT}, {11'h0, badr});
    chk("init", 16'h0, {15'h0, ini});
    chk("steps_mode", 16'h0, {15'h0, stm});
    chk("position", 16'h0, pos);
    chk("at_max", 16'h0, {15'h0, amax});
    chk("done", 16'h0, {15'h0, hd});
    chk("err_rst", 16'h0, {15'h0, err});
    chk("phase_rst", {14'h0, PH_NONE}, {14'h0, eph});
    chk("step_rst", 16'h0, {15'h0, step});
  endtask
  // address writes: bounds accepted, out of range refused and kept
  task automatic t_addr();
    logic [7:0] v[4] = '{8'h1e, 8'h1f, 8'hff, 8'h00};
    logic [4:0] exp = ADDR_DEFAULT;
    logic rej;
    for (int i = 0; i < 4; i++) begin
      bav = v[i];
      bas = 1;
      @(negedge clk);
      bas = 0;
      rej = brej;
      if (v[i] <= 8'h1e) exp = v[i][4:0];
      chk("addr_rej", {15'h0, v[i] > 8'h1e}, {15'h0, rej});
      chk("addr_val", {11'h0, exp}, {11'h0, badr});
      @(negedge clk);
      chk("addr_rej_pulse", 16'h0, {15'h0, brej});
    end
  endtask
  // channel settings gated by the active channel, reload from storage
  task automatic t_settings();
    act = 0;
    stc = 1;
    rcc = 1;
    @(negedge clk);
    stc = 0;
    rcc = 0;
    settle();
    chk("steps_inact", 16'h0, {15'h0, stm});
    chk("ref_inact", 16'h1, {15'h0, rco});
    act = 1;
    ecv = 1;
    ecc = 1;
    @(negedge clk);
    ecc = 0;
    settle();
    chk("long_drive", 16'h1, {15'h0, ldr});
    ecv = 0;
    ecc = 1;
    @(negedge clk);
    ecc = 0;
    nvf = 4'h8;
    nvl = 1;
    @(negedge clk);
    nvl = 0;
    settle();
    chk("nv_ref", 16'h0, {15'h0, rco});
    chk("nv_steps", 16'h1, {15'h0, stm});
    chk("nv_long", 16'h0, {15'h0, ldr});
  endtask
  // value mode from steps mode starts homing; min seen with max is an error
  task automatic t_homing();
    int n = 0;
    fmin = 1;
    vmc = 1;
    @(negedge clk);
    vmc = 0;
    while (step !== 1'b1 && n < 60000) begin
      @(negedge clk);
      n++;
    end
    chk("first_step", 16'h1, {15'h0, step});
    chk("dir_up", 16'h1, {15'h0, dup});
    n = 0;
    while (err !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("error", 16'h1, {15'h0, err});
    chk("err_phase", {14'h0, PH_CHECK}, {14'h0, eph});
    chk("not_init", 16'h0, {15'h0, ini});
  endtask
  // paused power-up homing waits for the acknowledge, then restarts homing with the error cleared
  task automatic t_ack();
    fmin = 0;
    phe = 0;
    pu = 1;
    @(negedge clk);
    pu = 0;
    repeat (20) @(negedge clk);
    chk("paused_err", 16'h1, {15'h0, err});
    chk("paused_dir", 16'h1, {15'h0, dup});
    ack = 1;
    @(negedge clk);
    ack = 0;
    repeat (4) @(negedge clk);
    chk("ack_err", 16'h0, {15'h0, err});
    chk("ack_phase", {14'h0, PH_NONE}, {14'h0, eph});
    chk("ref_dir", 16'h0, {15'h0, dup});
    chk("ack_not_init", 16'h0, {15'h0, ini});
  endtask
  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #8000000;
    fail_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    t_reset();
    t_addr();
    t_settings();
    t_homing();
    t_ack();
    end_of_test();
  end
endmodule
`default_nettype wire
